// File: rtl/adc_seq_pkg.sv
// Shared constants, types and helpers for the converter sequencer.
// Assumes a single system clock and a synchronous active-high reset.

package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Widths and conversion timing in converter clock cycles
  // ----------------------------------------------------------------
  localparam int RESULT_W = 10;
  localparam int CYC_W = 5;
  localparam logic [4:0] CONV_NORMAL = 5'h0d;   // 13 cycles
  localparam logic [4:0] CONV_FIRST = 5'h19;    // 25 cycles
  localparam logic [4:0] CONV_DIFF_SYNC = 5'h0e; // 14 cycles
  // Whole cycles before the falling edge that samples: 1.5, 13.5, 2.5
  localparam logic [4:0] SH_NORMAL = 5'h01;
  localparam logic [4:0] SH_FIRST = 5'h0d;
  localparam logic [4:0] SH_DIFF_SYNC = 5'h02;
  // Channel codes from this value up to below the upper one are differential
  localparam logic [4:0] DIFF_FIRST_CODE = 5'h08;
  localparam logic [4:0] DIFF_END_CODE = 5'h1e;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {SEQ_IDLE, SEQ_CONV} seq_state_t;

  typedef struct packed {
    logic [1:0] reference;
    logic [4:0] channel;
  } selection_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_differential(input logic [4:0] ch);
    return (ch >= DIFF_FIRST_CODE) && (ch < DIFF_END_CODE);
  endfunction

  function automatic logic [15:0] justify(input logic [RESULT_W-1:0] r, input logic left);
    return left ? {r, 6'h00} : {6'h00, r};
  endfunction

endpackage

// File: rtl/result_fifo.sv
// Small result FIFO between the sequencer and the result stream port.
// Assumes the writer checks in_ready or level before pushing.
`timescale 1ns/100ps

module result_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Occupancy
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] count;
  } fifo_state_t;

  fifo_state_t cs, next_cs;
  logic push, pop;

  // Handshakes from registered occupancy
  assign in_ready = (cs.count != (PW+1)'(DEPTH));
  assign out_valid = (cs.count != '0);
  assign out_data = cs.mem[cs.rd];
  assign level = cs.count;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer wrap relies on DEPTH being a power of two
  always_comb
  begin
    next_cs = cs;
    if (push)
    begin
      next_cs.mem[cs.wr] = in_data;
      next_cs.wr = cs.wr + 1'b1;
    end
    if (pop)
      next_cs.rd = cs.rd + 1'b1;
    if (push && !pop)
      next_cs.count = cs.count + 1'b1;
    else if (pop && !push)
      next_cs.count = cs.count - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cs <= '0;
    else
      cs <= next_cs;
  end
endmodule // result_fifo

// File: rtl/adc_clock_prescaler.sv
// Converter clock prescaler: one-cycle pulses at each converter clock edge.
// Assumes enable and select are synchronous to clk.
`timescale 1ns/100ps

module adc_clock_prescaler #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic [2:0] prescaler_select,
  // Converter clock edges
  output logic rise_tick,
  output logic fall_tick
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic rise;
    logic fall;
  } pre_state_t;

  pre_state_t cs, next_cs;
  logic [CNT_W-1:0] mask;

  // Division ratio 2^select, with select zero also giving two
  assign mask = (prescaler_select == 3'h0) ? CNT_W'(1) : CNT_W'((1 << prescaler_select) - 1);

  // Counter held at zero while disabled, free running while enabled
  always_comb
  begin
    next_cs = cs;
    next_cs.rise = 1'b0;
    next_cs.fall = 1'b0;
    if (!enable)
      next_cs.count = '0;
    else
    begin
      next_cs.count = (cs.count == mask) ? '0 : cs.count + 1'b1;
      next_cs.rise = (cs.count == mask);
      next_cs.fall = (cs.count == (mask >> 1));
    end
  end

  assign rise_tick = cs.rise;
  assign fall_tick = cs.fall;

  always_ff @(posedge clk)
  begin
    if (rst)
      cs <= '0;
    else
      cs <= next_cs;
  end
endmodule // adc_clock_prescaler

// File: rtl/sar_adc_conversion_sequencer.sv
// Conversion sequencer for a 10-bit successive-approximation converter.
// Assumes control strobes are one-cycle pulses synchronous to clk and that
// the core presents a settled result when a conversion completes.
// How it works
// - Result is 10 bits over two bytes, right or left justified.
// - Low-byte read blocks result updates until the high byte is read.
// - Completion flag still sets while updates are blocked.
// - Start bit reads high during conversion, cleared by hardware at end in single mode.
// - Channel change mid-conversion applies only in that conversion's last cycle.
// - Free-run converts continuously after first start, ignoring the flag.
// - Selections reach the converter only while enabled.
// - Prescaler counts while enabled and is held reset while disabled.
// - Converter clock ratio is chosen by the prescaler select field.
// - Single-ended conversion begins at next rising converter clock edge.
// - Normal conversion 13 cycles, first after enable 25 cycles.
// - Sample-and-hold at 1.5 cycles, 2.5 on 14-cycle differential, or 13.5 on the first conversion.
// - Completion stores result, sets flag, clears start bit in single mode.
// - Free-run restarts immediately after completion while the buffer has room for the next result, start bit stays high.
// - Differential timing aligns to an internal half-rate converter clock.
// - User-started differential takes 13 cycles, or 14 if half-rate high.
// - Automatically restarted differential conversions take 14 cycles.
// - Single-ended channels bypass the differential gain stage.
// - Selections track until start, lock, then track again in last cycle.
`timescale 1ns/100ps

module sar_adc_conversion_sequencer #(
  parameter int PRESCALE_W = 7,
  parameter int DEPTH = adc_seq_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control bits
  input wire logic converter_enable,
  input wire logic free_run_select,
  input wire logic result_left_justify,
  input wire logic [2:0] prescaler_select,
  input wire logic start_write,
  input wire logic flag_clear_write,
  input wire logic irq_ack,
  // Selection as written by software
  input wire logic [1:0] reference_select,
  input wire logic [4:0] channel_gain_select,
  // Data byte read strobes
  input wire logic low_read,
  input wire logic high_read,
  // Converter core
  input wire logic [adc_seq_pkg::RESULT_W-1:0] core_result,
  output logic [1:0] applied_reference,
  output logic [4:0] applied_channel,
  output logic gain_bypass,
  output logic sample_hold,
  output logic half_rate_converter_clock,
  // Status
  output logic start_conversion_bit,
  output logic conversion_complete_flag,
  output logic busy,
  output logic [7:0] result_high_byte,
  output logic [7:0] result_low_byte,
  // Result stream
  output logic stream_valid,
  input wire logic stream_ready,
  output logic [adc_seq_pkg::RESULT_W-1:0] stream_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    adc_seq_pkg::seq_state_t state;
    logic [adc_seq_pkg::CYC_W-1:0] cyc;
    logic [adc_seq_pkg::CYC_W-1:0] len;
    logic [adc_seq_pkg::CYC_W-1:0] sh;
    logic start_bit;
    logic flag;
    logic lock;
    logic first;
    logic half_rate;
    logic done;
    logic sample;
    logic bypass;
    logic [adc_seq_pkg::RESULT_W-1:0] raw;
    logic [15:0] bytes;
    adc_seq_pkg::selection_t applied;
  } seq_regs_t;

  seq_regs_t cs, next_cs;
  logic rise_tick, fall_tick;
  logic [$clog2(DEPTH):0] fifo_level;
  logic fifo_in_ready;
  logic applied_diff;
  logic last_cycle;

  // ----------------------------------------------------------------
  // Converter clock and result buffer
  // ----------------------------------------------------------------
  adc_clock_prescaler #(.CNT_W(PRESCALE_W)) u_prescaler (
    .clk(clk),
    .rst(rst),
    .enable(converter_enable),
    .prescaler_select(prescaler_select),
    .rise_tick(rise_tick),
    .fall_tick(fall_tick)
  );

  // A full buffer stalls new starts rather than dropping stream words
  result_fifo #(.WIDTH(adc_seq_pkg::RESULT_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(next_cs.done),
    .in_ready(fifo_in_ready),
    .in_data(core_result),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data(stream_data),
    .level(fifo_level)
  );

  assign applied_diff = adc_seq_pkg::is_differential(cs.applied.channel);
  assign last_cycle = (cs.state == adc_seq_pkg::SEQ_CONV) && (cs.cyc == cs.len - 1'b1);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Sequencing runs on converter clock edge pulses from the prescaler
  always_comb
  begin
    next_cs = cs;
    next_cs.done = 1'b0;
    next_cs.sample = 1'b0;
    if (!converter_enable)
    begin
      next_cs.state = adc_seq_pkg::SEQ_IDLE;
      next_cs.cyc = '0;
      next_cs.start_bit = 1'b0;
      next_cs.first = 1'b1;
      next_cs.half_rate = 1'b0;
    end
    else
    begin
      if (rise_tick)
        next_cs.half_rate = ~cs.half_rate;
      case (cs.state)
        adc_seq_pkg::SEQ_IDLE:
        begin
          // Start only with room left in the buffer
          if (rise_tick && cs.start_bit && (fifo_level < DEPTH))
          begin
            next_cs.state = adc_seq_pkg::SEQ_CONV;
            next_cs.cyc = '0;
            if (cs.first)
            begin
              next_cs.len = adc_seq_pkg::CONV_FIRST;
              next_cs.sh = adc_seq_pkg::SH_FIRST;
              next_cs.first = 1'b0;
            end
            else if (applied_diff && cs.half_rate)
            begin
              next_cs.len = adc_seq_pkg::CONV_DIFF_SYNC;
              next_cs.sh = adc_seq_pkg::SH_DIFF_SYNC;
            end
            else
            begin
              next_cs.len = adc_seq_pkg::CONV_NORMAL;
              next_cs.sh = adc_seq_pkg::SH_NORMAL;
            end
          end
        end
        adc_seq_pkg::SEQ_CONV:
        begin
          if (fall_tick && (cs.cyc == cs.sh))
            next_cs.sample = 1'b1;
          if (rise_tick)
          begin
            if (last_cycle)
            begin
              next_cs.done = 1'b1;
              // Auto restart needs room for this result and the next one
              if (free_run_select && (fifo_level < DEPTH - 1))
              begin
                next_cs.cyc = '0;
                next_cs.len = applied_diff ? adc_seq_pkg::CONV_DIFF_SYNC : adc_seq_pkg::CONV_NORMAL;
                next_cs.sh = applied_diff ? adc_seq_pkg::SH_DIFF_SYNC : adc_seq_pkg::SH_NORMAL;
              end
              else
                next_cs.state = adc_seq_pkg::SEQ_IDLE;
            end
            else
              next_cs.cyc = cs.cyc + 1'b1;
          end
        end
        default:
          next_cs.state = adc_seq_pkg::SEQ_IDLE;
      endcase
      // Start bit: hardware clear in single mode, a new write wins
      if (next_cs.done && !free_run_select)
        next_cs.start_bit = 1'b0;
      if (start_write)
        next_cs.start_bit = 1'b1;
    end
    // Selections track outside a conversion and in its last cycle
    if (converter_enable && ((cs.state == adc_seq_pkg::SEQ_IDLE) || last_cycle))
    begin
      next_cs.applied.reference = reference_select;
      next_cs.applied.channel = channel_gain_select;
    end
    next_cs.bypass = !applied_diff;
    // Flag is set independently of the byte lock; set beats clear
    if (flag_clear_write || irq_ack)
      next_cs.flag = 1'b0;
    if (next_cs.done)
      next_cs.flag = 1'b1;
    // Byte lock between low and high reads
    if (low_read)
      next_cs.lock = 1'b1;
    if (high_read)
      next_cs.lock = 1'b0;
    if (next_cs.done && !cs.lock)
      next_cs.raw = core_result;
    next_cs.bytes = adc_seq_pkg::justify(cs.raw, result_left_justify);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs <= '0;
      cs.state <= adc_seq_pkg::SEQ_IDLE;
      cs.first <= 1'b1;
      cs.bypass <= 1'b1;
    end
    else
      cs <= next_cs;
  end

  // Outputs straight from the state register
  assign applied_reference = cs.applied.reference;
  assign applied_channel = cs.applied.channel;
  assign gain_bypass = cs.bypass;
  assign sample_hold = cs.sample;
  assign half_rate_converter_clock = cs.half_rate;
  assign start_conversion_bit = cs.start_bit;
  assign conversion_complete_flag = cs.flag;
  assign busy = (cs.state == adc_seq_pkg::SEQ_CONV);
  assign result_high_byte = cs.bytes[15:8];
  assign result_low_byte = cs.bytes[7:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_flag_on_done;
    @(posedge clk) disable iff (rst) cs.done |-> conversion_complete_flag;
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set at completion");

  property p_lock_holds;
    @(posedge clk) disable iff (rst) (cs.lock && !high_read) |=> $stable(cs.raw);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("result updated while locked");

  property p_single_clear;
    @(posedge clk) disable iff (rst)
      (next_cs.done && !free_run_select && !start_write && converter_enable) |=> !start_conversion_bit;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("start bit not cleared");

  property p_busy_start;
    @(posedge clk) disable iff (rst) busy && !cs.done |-> start_conversion_bit || free_run_select;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start bit low during conversion");

  property p_free_keeps;
    @(posedge clk) disable iff (rst) (next_cs.done && free_run_select && converter_enable) |=> start_conversion_bit;
  endproperty
  a_free_keeps: assert property (p_free_keeps) else $error("start bit dropped in free run");

  property p_prescale_held;
    @(posedge clk) disable iff (rst) !converter_enable [*2] |=> !rise_tick && !fall_tick;
  endproperty
  a_prescale_held: assert property (p_prescale_held) else $error("prescaler ran while disabled");

  property p_select_locked;
    @(posedge clk) disable iff (rst) (busy && !last_cycle) |=> $stable(applied_channel) && $stable(applied_reference);
  endproperty
  a_select_locked: assert property (p_select_locked) else $error("selection changed mid conversion");

  property p_enable_gate;
    @(posedge clk) disable iff (rst) !converter_enable |=> $stable(applied_channel);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("selection applied while disabled");

  property p_first_len;
    @(posedge clk) disable iff (rst)
      (cs.state == adc_seq_pkg::SEQ_IDLE && next_cs.state == adc_seq_pkg::SEQ_CONV && cs.first)
      |=> cs.len == 5'h19 && cs.sh == 5'h0d;
  endproperty
  a_first_len: assert property (p_first_len) else $error("first conversion not 25 cycles");

  property p_auto_diff;
    @(posedge clk) disable iff (rst)
      (next_cs.done && next_cs.state == adc_seq_pkg::SEQ_CONV && applied_diff) |=> cs.len == 5'h0e;
  endproperty
  a_auto_diff: assert property (p_auto_diff) else $error("auto restart not 14 cycles");

  property p_flag_clear;
    @(posedge clk) disable iff (rst) (irq_ack || flag_clear_write) && !next_cs.done |=> !conversion_complete_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_justify;
    @(posedge clk) disable iff (rst)
      ##1 {result_high_byte, result_low_byte} == adc_seq_pkg::justify($past(cs.raw), $past(result_left_justify));
  endproperty
  a_justify: assert property (p_justify) else $error("result bytes misjustified");

  property p_bypass;
    @(posedge clk) disable iff (rst) ##1 gain_bypass == !adc_seq_pkg::is_differential($past(applied_channel));
  endproperty
  a_bypass: assert property (p_bypass) else $error("gain bypass wrong");

  property p_user_diff;
    @(posedge clk) disable iff (rst)
      (cs.state == adc_seq_pkg::SEQ_IDLE && next_cs.state == adc_seq_pkg::SEQ_CONV && !cs.first && applied_diff)
      |=> cs.len == ($past(cs.half_rate) ? 5'h0e : 5'h0d);
  endproperty
  a_user_diff: assert property (p_user_diff) else $error("user differential length wrong");

  // A completion must never meet a full buffer, or a stream word is lost
  property p_push_room;
    @(posedge clk) disable iff (rst) next_cs.done |-> fifo_in_ready;
  endproperty
  a_push_room: assert property (p_push_room) else $error("result pushed into full buffer");

  // Main scenarios
  c_first_done: cover property (@(posedge clk) disable iff (rst) cs.done && !free_run_select);
  c_free_run: cover property (@(posedge clk) disable iff (rst) cs.done && free_run_select ##[1:400] cs.done);
  c_lost_result: cover property (@(posedge clk) disable iff (rst) cs.done && cs.lock);
  c_diff_sync: cover property (@(posedge clk) disable iff (rst) busy && cs.len == 5'h0e);

endmodule // sar_adc_conversion_sequencer

// File: verification/core_model.sv
// Behavioural converter core that samples the applied selection.
// Assumes the sequencer takes core_result only at completion.
`timescale 1ns/100ps

module core_model (
  // Clock
  input wire logic clk,
  // From the sequencer
  input wire logic [1:0] applied_reference,
  input wire logic [4:0] applied_channel,
  input wire logic gain_bypass,
  input wire logic sample_hold,
  // To the sequencer and bench
  output logic [adc_seq_pkg::RESULT_W-1:0] core_result,
  output int sh_count
);
  // ----------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------
  // Path code in the word, so a wrong bypass shows in the result
  initial
  begin
    core_result = 10'h000;
    sh_count = 0;
  end
  always @(posedge clk)
  begin
    if (sample_hold)
    begin
      core_result <= {applied_reference, gain_bypass ? 3'h5 : 3'h2, applied_channel};
      sh_count <= sh_count + 1;
    end
  end
endmodule // core_model

// File: verification/testbench.sv
// Self-checking bench for the conversion sequencer.
// Assumes core_model stands in for the analogue core.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module testbench;
  typedef struct {logic [4:0] ch; logic [1:0] rf; logic lj; logic [2:0] ps; int len;} row_t;
  logic clk, rst, en, fr, lj, sw, fcw, ack, lr, hr, sr, gb, sh, hrc, sb, flag, busy, sv, hv;
  logic [2:0] ps;
  logic [1:0] rf, a_ref;
  logic [4:0] ch, a_ch;
  logic [9:0] core_result, stream_data;
  logic [7:0] hb, lb;
  logic [15:0] w;
  int sh_count, num_errors, compares, cycles, n, k;
  row_t rows[4];

  // ----------------------------------------------------------
  // Design and core
  // ----------------------------------------------------------
  sar_adc_conversion_sequencer dut_u (.clk(clk), .rst(rst), .converter_enable(en), .free_run_select(fr),
    .result_left_justify(lj), .prescaler_select(ps), .start_write(sw), .flag_clear_write(fcw),
    .irq_ack(ack), .reference_select(rf), .channel_gain_select(ch), .low_read(lr), .high_read(hr),
    .core_result(core_result), .applied_reference(a_ref), .applied_channel(a_ch), .gain_bypass(gb),
    .sample_hold(sh), .half_rate_converter_clock(hrc), .start_conversion_bit(sb),
    .conversion_complete_flag(flag), .busy(busy), .result_high_byte(hb), .result_low_byte(lb),
    .stream_valid(sv), .stream_ready(sr), .stream_data(stream_data));
  core_model core_u (.clk(clk), .applied_reference(a_ref), .applied_channel(a_ch), .gain_bypass(gb),
    .sample_hold(sh), .core_result(core_result), .sh_count(sh_count));

  // ----------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Ceiling well above the several hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  function automatic int ratio(logic [2:0] p);
    return (p == 3'h0) ? 2 : (1 << p);
  endfunction
  // Word the core model gives for a selection
  function automatic logic [9:0] expr(logic [1:0] f, logic [4:0] c);
    return {f, (c < 5'h08 || c > 5'h1d) ? 3'h5 : 3'h2, c};
  endfunction
  task automatic step(int m);
    repeat (m) @(posedge clk);
  endtask
  // One-cycle strobe: start, flag clear, ack, low read, high read
  task automatic strobe(int s);
    @(posedge clk);
    case (s)
      0: sw <= 1'b1;
      1: fcw <= 1'b1;
      2: ack <= 1'b1;
      3: lr <= 1'b1;
      default: hr <= 1'b1;
    endcase
    @(posedge clk);
    {sw, fcw, ack, lr, hr} <= 5'h00;
  endtask
  // Busy length in clk cycles is conversion ticks times ratio
  task automatic wait_conv(int e);
    n = 0;
    while (busy !== 1'b1) @(posedge clk);
    while (busy === 1'b1)
    begin
      n++;
      @(posedge clk);
    end
    `CHK("conversion length", e, n)
  endtask
  task automatic check_done(logic [9:0] r, logic l, logic single);
    `CHK("flag", 1'b1, flag)
    `CHK("start bit", ~single, sb)
    step(3);
    w = l ? {r, 6'h00} : {6'h00, r};
    `CHK("high byte", w[15:8], hb)
    `CHK("low byte", w[7:0], lb)
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    {rst, en, fr, lj, sw, fcw, ack, lr, hr, sr} = 10'h200;
    ps = 3'h0;
    rf = 2'h0;
    ch = 5'h00;
    rows[0] = '{5'h03, 2'h1, 1'b0, 3'h0, 25};
    rows[1] = '{5'h05, 2'h2, 1'b1, 3'h2, 13};
    rows[2] = '{5'h1e, 2'h3, 1'b0, 3'h3, 13};
    rows[3] = '{5'h1f, 2'h0, 1'b1, 3'h1, 13};
    step(3);
    rst <= 1'b0;
    step(2);
    `CHK("busy after reset", 1'b0, busy)
    `CHK("flag after reset", 1'b0, flag)
    `CHK("start after reset", 1'b0, sb)
    `CHK("bypass after reset", 1'b1, gb)
    en <= 1'b1;
    // Rows: stream stalled, so four results fill the buffer
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      ch <= rows[i].ch;
      rf <= rows[i].rf;
      lj <= rows[i].lj;
      ps <= rows[i].ps;
      step(3);
      `CHK("applied channel", rows[i].ch, a_ch)
      `CHK("applied reference", rows[i].rf, a_ref)
      `CHK("gain bypass", 1'b1, gb)
      k = sh_count;
      strobe(0);
      wait_conv(rows[i].len * ratio(rows[i].ps));
      `CHK("sample-hold count", k + 1, sh_count)
      check_done(expr(rows[i].rf, rows[i].ch), rows[i].lj, 1'b1);
      strobe(1 + i % 2);
      step(1);
      `CHK("flag cleared", 1'b0, flag)
      strobe(3);
      strobe(4);
    end
    // Full buffer holds the start back until the first word is popped
    strobe(0);
    step(40);
    `CHK("start held on full buffer", 1'b0, busy)
    `CHK("start bit pending", 1'b1, sb)
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      `CHK("stream valid", 1'b1, sv)
      `CHK("stream data", expr(rows[i].rf, rows[i].ch), stream_data)
      sr <= 1'b1;
      @(posedge clk);
      sr <= 1'b0;
    end
    @(posedge clk);
    `CHK("stream empty", 1'b0, sv)
    // The held start went off at the first pop, so it is already running
    `CHK("start after room", 1'b1, busy)
    sr <= 1'b1;
    while (busy === 1'b1) @(posedge clk);
    check_done(expr(2'h0, 5'h1f), 1'b1, 1'b1);
    // Low read locks the bytes; the flag still rises
    strobe(1);
    @(posedge clk);
    ch <= 5'h02;
    strobe(3);
    strobe(0);
    wait_conv(26);
    `CHK("flag while locked", 1'b1, flag)
    step(3);
    w = {expr(2'h0, 5'h1f), 6'h00};
    `CHK("locked high byte", w[15:8], hb)
    `CHK("locked low byte", w[7:0], lb)
    strobe(4);
    strobe(2);
    strobe(0);
    wait_conv(26);
    check_done(expr(2'h0, 5'h02), 1'b1, 1'b1);
    // Channel change during a conversion waits for its end
    @(posedge clk);
    ch <= 5'h04;
    step(3);
    strobe(0);
    while (busy !== 1'b1) @(posedge clk);
    step(4);
    ch <= 5'h06;
    step(6);
    `CHK("channel locked", 5'h04, a_ch)
    while (busy === 1'b1) @(posedge clk);
    check_done(expr(2'h0, 5'h04), 1'b1, 1'b1);
    `CHK("channel tracks again", 5'h06, a_ch)
    // Free run on a differential channel, flag left set
    @(posedge clk);
    ch <= 5'h08;
    fr <= 1'b1;
    step(3);
    `CHK("gain stage used", 1'b0, gb)
    strobe(0);
    for (int i = 0; i < 3; i++)
    begin
      n = 0;
      @(posedge clk);
      while (sh !== 1'b1)
      begin
        n++;
        @(posedge clk);
      end
      `CHK("start bit in free run", 1'b1, sb)
    end
    `CHK("auto restart period", 28, n + 1)
    fr <= 1'b0;
    step(2);
    while (busy === 1'b1) @(posedge clk);
    step(2);
    `CHK("start bit after free run", 1'b0, sb)
    // Disabled: selection frozen, start ignored, then long first conversion
    en <= 1'b0;
    ch <= 5'h01;
    step(4);
    `CHK("selection frozen", 5'h08, a_ch)
    strobe(0);
    step(20);
    `CHK("idle while disabled", 1'b0, busy)
    `CHK("start ignored", 1'b0, sb)
    en <= 1'b1;
    step(3);
    `CHK("selection applied", 5'h01, a_ch)
    hv = hrc;
    step(2);
    `CHK("half-rate toggles", ~hv, hrc)
    strobe(1);
    strobe(0);
    wait_conv(50);
    check_done(expr(2'h0, 5'h01), 1'b1, 1'b1);
    complete_run();
  end
endmodule // testbench
